// ---- logic/mts_timer_top.sv ----
// Multi-timer subsystem: prescaler, two reload timers, long timer, display clock, watchdog
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Down counter with reload: underflows after reload+1 ticks
module mts_down_counter #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic         load,
  input  wire logic [W-1:0] reload,
  output logic      [W-1:0] count,
  output logic              underflow
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Next count: reload on underflow keeps the period without software help
  always_comb begin
    cnt_nxt   = cnt_r;
    underflow = 1'b0;
    if (load) begin
      cnt_nxt = reload;
    end else if (tick && run) begin
      if (cnt_r == '0) begin
        cnt_nxt   = reload;
        underflow = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  // Stopped counter retains its state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
endmodule

// Summary of operation
// - Reload timers underflow after n+1 pulses, flag set
// - Underflow reloads counter, counting continues automatically
// - Fixed-ratio timer flags once every n pulses
// - Prescaler divides instruction tick by 1..256
// - First timer counts one of four sources
// - Second timer: PWM, main osc or prescaler/2
// - Long timer 16-bit, ratio 8192 to 65536
// - Long underflow feeds first timer; long bit 4 feeds display timer
// - Display timer divides 1..16, drives LCD clock
// - Watchdog free-runs on instruction tick, no control
// - Watchdog: flag after one period, reset after two
// - Three timers own independent request flags
// - Software controls timers through control registers
// - Timer flags cleared by acceptance or skip clear; watchdog flag by skip clear only
// - Long ratio select 00..11 gives 8192..65536
// - First source select: PWM, prescaler, long, pin
// - Sync start waits for external interrupt edge
module mts_timer_top #(
  parameter int PRESC_W = 8,
  parameter int TIMER_W = 8,
  parameter int DISP_W  = 4,
  parameter int LONG_W  = 16
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        instruction_clock_tick,
  input  wire logic        system_clock_tick,
  input  wire logic        main_osc_pin,
  input  wire logic        sub_osc_pin,
  input  wire logic        counter_pin,
  input  wire logic        extIntEdge,
  input  wire logic [2:0]  intAccept,
  output logic             pwm_wave,
  output logic             counterPinOut,
  output logic             lcdClock,
  output logic [2:0]       timerIrq,
  output logic             watchdog_flag,
  output logic             sysResetReq
);
  // Control and reload registers
  logic                       prescRun_r,  prescRun_nxt;
  logic [PRESC_W-1:0]         prescReld_r, prescReld_nxt;
  logic [3:0]                 firstCtl_r,  firstCtl_nxt;
  logic [TIMER_W-1:0]         firstReld_r, firstReld_nxt;
  logic [3:0]                 secondCtl_r, secondCtl_nxt;
  logic [TIMER_W-1:0]         secondReld_r, secondReld_nxt;
  logic [3:0]                 longCtl_r,   longCtl_nxt;
  logic [5:0]                 dispCtl_r,   dispCtl_nxt;
  mts_pkg::mts_flags_t        flags_r,     flags_nxt;
  logic                       ack_r,       ack_nxt;
  logic [31:0]                rdata_r,     rdata_nxt;

  // Timer state
  logic                       mainOsc_r, subOsc_r, cpin_r;
  logic                       div2_r,    div2_nxt;
  logic                       pwm_r,     pwm_nxt;
  logic                       firstOut_r, firstOut_nxt;
  logic                       lcd_r,     lcd_nxt;
  logic                       syncGo_r,  syncGo_nxt;
  logic [LONG_W-1:0]          long_r,    long_nxt;
  logic [15:0]                wdog_r,    wdog_nxt;
  logic                       rst_r,     rst_nxt;
  logic                       cpo_r,     cpo_nxt;

  // Derived pulses
  logic                       req, wrEn, rdEn;
  logic                       prescUf, firstUf, secondUf, longUf, dispUf, wdogDone;
  logic                       prescTick2, secondTick, firstTick, longTick, dispTick;
  logic                       firstRun, longTap, pwmRise;
  logic [TIMER_W-1:0]         firstCnt, secondCnt;
  logic [PRESC_W-1:0]         prescCnt;
  logic [DISP_W-1:0]          dispCnt;
  logic [LONG_W-1:0]          longMask;
  mts_pkg::mts_flags_t        setF, clrF;

  // One wait state per access; read data is captured before waitrequest drops
  assign req         = read | write;
  assign waitrequest = req & ~ack_r;
  assign wrEn        = write & ack_r;
  assign rdEn        = read & ~ack_r;

  assign pwmRise    = pwm_nxt & ~pwm_r;
  assign prescTick2 = prescUf & div2_r;
  assign secondTick = secondCtl_r[mts_pkg::SECOND_SRC_BIT] ? prescTick2
                                                            : (main_osc_pin & ~mainOsc_r);
  assign longTick   = longCtl_r[mts_pkg::LONG_SRC_BIT] ? prescUf : (sub_osc_pin & ~subOsc_r);
  assign longMask   = LONG_W'((32'h1 << (mts_pkg::LONG_BASE_LOG2
                                         + int'(longCtl_r[1:0]))) - 1);
  assign longUf     = longTick & longCtl_r[mts_pkg::LONG_RUN_BIT]
                      & ((long_r & longMask) == longMask);
  // Display source takes the falling edge of the tap bit
  assign longTap    = longTick & longCtl_r[mts_pkg::LONG_RUN_BIT]
                      & (long_r[mts_pkg::LONG_TAP_BIT:0] == '1);
  assign dispTick   = dispCtl_r[mts_pkg::DISP_SRC_BIT] ? system_clock_tick : longTap;
  assign firstRun   = firstCtl_r[mts_pkg::FIRST_RUN_BIT]
                      & (~firstCtl_r[mts_pkg::FIRST_SYNC_BIT] | syncGo_r);

  always_comb begin
    case (firstCtl_r[1:0])
      mts_pkg::SRC_PWM:    firstTick = pwmRise;
      mts_pkg::SRC_PRESC:  firstTick = prescUf;
      mts_pkg::SRC_LONGUF: firstTick = longUf;
      mts_pkg::SRC_CPIN:   firstTick = counter_pin & ~cpin_r;
      default:             firstTick = 1'b0;
    endcase
  end

  mts_down_counter #(.W(PRESC_W)) presc_u (
    .clock(clock), .rst_n(rst_n), .ce(ce), .tick(instruction_clock_tick),
    .run(prescRun_r), .load(wrEn && address == mts_pkg::PRESC_RELD_OFS),
    .reload(prescReld_nxt), .count(prescCnt), .underflow(prescUf)
  );
  mts_down_counter #(.W(TIMER_W)) first_u (
    .clock(clock), .rst_n(rst_n), .ce(ce), .tick(firstTick), .run(firstRun),
    .load(wrEn && address == mts_pkg::FIRST_RELD_OFS),
    .reload(firstReld_nxt), .count(firstCnt), .underflow(firstUf)
  );
  mts_down_counter #(.W(TIMER_W)) second_u (
    .clock(clock), .rst_n(rst_n), .ce(ce), .tick(secondTick),
    .run(secondCtl_r[mts_pkg::SECOND_RUN_BIT]),
    .load(wrEn && address == mts_pkg::SECOND_RELD_OFS),
    .reload(secondReld_nxt), .count(secondCnt), .underflow(secondUf)
  );
  mts_down_counter #(.W(DISP_W)) disp_u (
    .clock(clock), .rst_n(rst_n), .ce(ce), .tick(dispTick),
    .run(dispCtl_r[mts_pkg::DISP_RUN_BIT]),
    .load(wrEn && address == mts_pkg::DISP_CTRL_OFS),
    .reload(dispCtl_nxt[DISP_W-1:0]), .count(dispCnt), .underflow(dispUf)
  );

  assign wdogDone = instruction_clock_tick & (wdog_r == mts_pkg::WDOG_RATIO - 16'h1);

  // Register writes; reload values also feed the counters' load path
  always_comb begin
    prescRun_nxt   = prescRun_r;
    prescReld_nxt  = prescReld_r;
    firstCtl_nxt   = firstCtl_r;
    firstReld_nxt  = firstReld_r;
    secondCtl_nxt  = secondCtl_r;
    secondReld_nxt = secondReld_r;
    longCtl_nxt    = longCtl_r;
    dispCtl_nxt    = dispCtl_r;
    clrF           = '0;
    if (wrEn) begin
      case (address)
        mts_pkg::PRESC_CTRL_OFS:  prescRun_nxt   = writedata[mts_pkg::PRESC_RUN_BIT];
        mts_pkg::PRESC_RELD_OFS:  prescReld_nxt  = writedata[PRESC_W-1:0];
        mts_pkg::FIRST_CTRL_OFS:  firstCtl_nxt   = writedata[3:0];
        mts_pkg::FIRST_RELD_OFS:  firstReld_nxt  = writedata[TIMER_W-1:0];
        mts_pkg::SECOND_CTRL_OFS: secondCtl_nxt  = writedata[3:0];
        mts_pkg::SECOND_RELD_OFS: secondReld_nxt = writedata[TIMER_W-1:0];
        mts_pkg::LONG_CTRL_OFS:   longCtl_nxt    = writedata[3:0];
        mts_pkg::DISP_CTRL_OFS:   dispCtl_nxt    = writedata[5:0];
        mts_pkg::FLAGS_OFS:       clrF           = mts_pkg::mts_flags_t'(writedata[3:0]);
        default:                  clrF           = '0;
      endcase
    end
  end

  // Request flags: a set in the same cycle as a clear wins
  always_comb begin
    setF        = '0;
    setF.first  = firstUf;
    setF.second = secondUf;
    setF.longT  = longUf;
    setF.wdog   = wdogDone;
    flags_nxt   = flags_r;
    flags_nxt.first  = setF.first  | (flags_r.first  & ~clrF.first  & ~intAccept[0]);
    flags_nxt.second = setF.second | (flags_r.second & ~clrF.second & ~intAccept[1]);
    flags_nxt.longT  = setF.longT  | (flags_r.longT  & ~clrF.longT  & ~intAccept[2]);
    flags_nxt.wdog   = setF.wdog   | (flags_r.wdog   & ~clrF.wdog);
  end

  // Read mux; unmapped offsets return zero
  always_comb begin
    rdata_nxt = rdata_r;
    ack_nxt   = req & ~ack_r;
    if (rdEn) begin
      case (address)
        mts_pkg::PRESC_CTRL_OFS:  rdata_nxt = 32'(prescRun_r);
        mts_pkg::PRESC_RELD_OFS:  rdata_nxt = 32'(prescReld_r);
        mts_pkg::FIRST_CTRL_OFS:  rdata_nxt = 32'(firstCtl_r);
        mts_pkg::FIRST_RELD_OFS:  rdata_nxt = 32'(firstReld_r);
        mts_pkg::SECOND_CTRL_OFS: rdata_nxt = 32'(secondCtl_r);
        mts_pkg::SECOND_RELD_OFS: rdata_nxt = 32'(secondReld_r);
        mts_pkg::LONG_CTRL_OFS:   rdata_nxt = 32'(longCtl_r);
        mts_pkg::DISP_CTRL_OFS:   rdata_nxt = 32'(dispCtl_r);
        mts_pkg::FLAGS_OFS:       rdata_nxt = 32'(flags_r);
        mts_pkg::FIRST_CNT_OFS:   rdata_nxt = 32'(firstCnt);
        mts_pkg::SECOND_CNT_OFS:  rdata_nxt = 32'(secondCnt);
        mts_pkg::LONG_CNT_OFS:    rdata_nxt = 32'(long_r);
        mts_pkg::WDOG_CNT_OFS:    rdata_nxt = 32'(wdog_r);
        default:                  rdata_nxt = 32'h0;
      endcase
    end
  end

  // Timer side state: dividers, outputs, long counter, watchdog
  always_comb begin
    div2_nxt     = prescUf ? ~div2_r : div2_r;
    pwm_nxt      = secondUf ? ~pwm_r : pwm_r;
    firstOut_nxt = firstUf ? ~firstOut_r : firstOut_r;
    lcd_nxt      = dispUf ? ~lcd_r : lcd_r;
    // Arm clears when first timer is stopped so the next start waits again
    syncGo_nxt   = firstCtl_r[mts_pkg::FIRST_RUN_BIT] & (syncGo_r | extIntEdge);
    long_nxt     = (longTick && longCtl_r[mts_pkg::LONG_RUN_BIT]) ? long_r + 1'b1 : long_r;
    wdog_nxt     = wdogDone ? 16'h0
                 : (instruction_clock_tick ? wdog_r + 16'h1 : wdog_r);
    rst_nxt      = wdogDone & flags_r.wdog;
    cpo_nxt      = secondCtl_r[mts_pkg::SECOND_CPO_BIT] & pwm_r & firstOut_r;
  end

  // Register everything; clock enable freezes all state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prescRun_r   <= 1'b0;
      prescReld_r  <= mts_pkg::RELD8_RST;
      firstCtl_r   <= mts_pkg::CTRL_RST;
      firstReld_r  <= mts_pkg::RELD8_RST;
      secondCtl_r  <= mts_pkg::CTRL_RST;
      secondReld_r <= mts_pkg::RELD8_RST;
      longCtl_r    <= mts_pkg::CTRL_RST;
      dispCtl_r    <= mts_pkg::DISP_RST;
      flags_r      <= '0;
      ack_r        <= 1'b0;
      rdata_r      <= 32'h0;
      mainOsc_r    <= 1'b0;
      subOsc_r     <= 1'b0;
      cpin_r       <= 1'b0;
      div2_r       <= 1'b0;
      pwm_r        <= 1'b0;
      firstOut_r   <= 1'b1;
      lcd_r        <= 1'b0;
      syncGo_r     <= 1'b0;
      long_r       <= '0;
      wdog_r       <= 16'h0;
      rst_r        <= 1'b0;
      cpo_r        <= 1'b0;
    end else if (ce) begin
      prescRun_r   <= prescRun_nxt;
      prescReld_r  <= prescReld_nxt;
      firstCtl_r   <= firstCtl_nxt;
      firstReld_r  <= firstReld_nxt;
      secondCtl_r  <= secondCtl_nxt;
      secondReld_r <= secondReld_nxt;
      longCtl_r    <= longCtl_nxt;
      dispCtl_r    <= dispCtl_nxt;
      flags_r      <= flags_nxt;
      ack_r        <= ack_nxt;
      rdata_r      <= rdata_nxt;
      mainOsc_r    <= main_osc_pin;
      subOsc_r     <= sub_osc_pin;
      cpin_r       <= counter_pin;
      div2_r       <= div2_nxt;
      pwm_r        <= pwm_nxt;
      firstOut_r   <= firstOut_nxt;
      lcd_r        <= lcd_nxt;
      syncGo_r     <= syncGo_nxt;
      long_r       <= long_nxt;
      wdog_r       <= wdog_nxt;
      rst_r        <= rst_nxt;
      cpo_r        <= cpo_nxt;
    end
  end

  assign readdata      = rdata_r;
  assign pwm_wave      = pwm_r;
  assign counterPinOut = cpo_r;
  assign lcdClock      = lcd_r;
  assign timerIrq      = {flags_r.longT, flags_r.second, flags_r.first};
  assign watchdog_flag = flags_r.wdog;
  assign sysResetReq   = rst_r;
endmodule

`default_nettype wire

// ---- logic/mts_pkg.sv ----
// Package for the multi-timer subsystem: register map, field positions, reset values, counts
package mts_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] PRESC_CTRL_OFS  = 6'h00;
  localparam logic [5:0] PRESC_RELD_OFS  = 6'h04;
  localparam logic [5:0] FIRST_CTRL_OFS  = 6'h08;
  localparam logic [5:0] FIRST_RELD_OFS  = 6'h0c;
  localparam logic [5:0] SECOND_CTRL_OFS = 6'h10;
  localparam logic [5:0] SECOND_RELD_OFS = 6'h14;
  localparam logic [5:0] LONG_CTRL_OFS   = 6'h18;
  localparam logic [5:0] DISP_CTRL_OFS   = 6'h1c;
  localparam logic [5:0] FLAGS_OFS       = 6'h20;
  localparam logic [5:0] FIRST_CNT_OFS   = 6'h24;
  localparam logic [5:0] SECOND_CNT_OFS  = 6'h28;
  localparam logic [5:0] LONG_CNT_OFS    = 6'h2c;
  localparam logic [5:0] WDOG_CNT_OFS    = 6'h30;

  // Field positions
  localparam int PRESC_RUN_BIT   = 0;
  localparam int FIRST_SRC_LSB   = 0;
  localparam int FIRST_RUN_BIT   = 2;
  localparam int FIRST_SYNC_BIT  = 3;
  localparam int SECOND_SRC_BIT  = 0;
  localparam int SECOND_RUN_BIT  = 1;
  localparam int SECOND_CPO_BIT  = 3;
  localparam int LONG_RATIO_LSB  = 0;
  localparam int LONG_RUN_BIT    = 2;
  localparam int LONG_SRC_BIT    = 3;
  localparam int DISP_RELD_LSB   = 0;
  localparam int DISP_SRC_BIT    = 4;
  localparam int DISP_RUN_BIT    = 5;

  // Reset values
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [7:0] RELD8_RST  = 8'h00;
  localparam logic [5:0] DISP_RST   = 6'h00;

  // First timer source encodings
  localparam logic [1:0] SRC_PWM    = 2'h0;
  localparam logic [1:0] SRC_PRESC  = 2'h1;
  localparam logic [1:0] SRC_LONGUF = 2'h2;
  localparam logic [1:0] SRC_CPIN   = 2'h3;

  // Long timer ratio: 2 to the power (LONG_BASE_LOG2 + select)
  localparam int LONG_BASE_LOG2 = 13;
  // Long timer bit that feeds the display clock timer
  localparam int LONG_TAP_BIT   = 4;
  // Watchdog division ratio
  localparam logic [15:0] WDOG_RATIO = 16'hfffe;

  // Sticky request flags
  typedef struct packed {
    logic wdog;
    logic longT;
    logic second;
    logic first;
  } mts_flags_t;
endpackage

// ---- bench/mts_timer_sva.sv ----
// Port-level concurrent checks for the multi-timer subsystem
`timescale 1ns/1ps
`default_nettype none
module mts_timer_sva (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        instruction_clock_tick,
  input wire logic [2:0]  intAccept,
  input wire logic [2:0]  timerIrq,
  input wire logic        pwm_wave,
  input wire logic        counterPinOut,
  input wire logic        watchdog_flag,
  input wire logic        sysResetReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] wdTicks_r;
  logic [31:0] wdTicks_nxt;
  logic        flagWr;
  // Accepted write to the flag register, which clears the bits written as one
  assign flagWr = write && !waitrequest && address == mts_pkg::FLAGS_OFS;
  // Tick count since reset, the reference for the watchdog period
  always_comb begin
    wdTicks_nxt = wdTicks_r;
    if (ce && instruction_clock_tick) begin
      wdTicks_nxt = wdTicks_r + 32'h1;
    end
  end
  always_ff @(posedge clock) begin
    wdTicks_r <= rst_n ? wdTicks_nxt : 32'h0;
  end
  sequence reqOpen;
    ce && (read || write) && !$past(read || write);
  endsequence
  sequence oneWait;
    waitrequest ##1 !waitrequest;
  endsequence
  // Flag holds until accepted or cleared; a set never drops alone
  property sticky(b);
    timerIrq[b] && !intAccept[b] && !(flagWr && writedata[b]) |=> timerIrq[b];
  endproperty
  bus_wait_a: assert property (reqOpen |-> oneWait)
    else $error("bus access wait state wrong");
  idle_ready_a: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high while idle");
  unmapped_read_a: assert property (read && !waitrequest
    && address > mts_pkg::WDOG_CNT_OFS |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0)
    else $error("read data upper bits set");
  irq_first_a: assert property (sticky(0))
    else $error("first flag dropped");
  irq_second_a: assert property (sticky(1))
    else $error("second flag dropped");
  irq_long_a: assert property (sticky(2))
    else $error("long flag dropped");
  wdog_sticky_a: assert property (watchdog_flag
    && !(flagWr && writedata[3]) |=> watchdog_flag)
    else $error("watchdog flag dropped");
  wdog_period_a: assert property ($rose(watchdog_flag)
    && wdTicks_r < 32'h10000 |-> wdTicks_r == 32'hfffe)
    else $error("watchdog flag at wrong tick");
  reset_pulse_a: assert property (sysResetReq
    |-> $past(watchdog_flag) ##1 !sysResetReq)
    else $error("system reset request wrong");
  pin_gate_a: assert property (counterPinOut |-> $past(pwm_wave))
    else $error("counter pin out without wave");
endmodule
`default_nettype wire

// ---- bench/mts_timer_top_bench.sv ----
// Self-checking bench for the multi-timer subsystem
`timescale 1ns/1ps
`default_nettype none
module mts_timer_top_bench;
  typedef struct {string nm; logic [31:0] v;} mts_exp_t;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        instTick = 1'b1;
  logic        cpin = 1'b0;
  logic        extEdge = 1'b0;
  logic [2:0]  intAccept = 3'h0;
  logic [31:0] readdata;
  logic        waitrequest, pwmWave, cpOut, lcdClock, wdFlag, sysRst, wdSeen = 1'b0;
  logic [2:0]  timerIrq;
  logic [31:0] ticks = 32'h0;
  logic [7:0]  seed = 8'h04;
  int          failures = 0;
  int          cmp_count = 0;
  mts_exp_t    expQ[$];
  mts_exp_t    cur;
  always #4 clock = ~clock;
  mts_timer_top dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .instruction_clock_tick(instTick),
    .system_clock_tick(instTick), .main_osc_pin(cpin), .sub_osc_pin(1'b0),
    .counter_pin(cpin), .extIntEdge(extEdge), .intAccept(intAccept), .pwm_wave(pwmWave),
    .counterPinOut(cpOut), .lcdClock(lcdClock), .timerIrq(timerIrq),
    .watchdog_flag(wdFlag), .sysResetReq(sysRst));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch and ends the run
  task automatic tmo(input logic hung);
    if (hung) begin
      failures++;
      end_sim();
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    read <= 1'b0;
    write <= 1'b0;
    tmo(waitrequest !== 1'b0);
  endtask
  task automatic rd(input logic [5:0] a, input string nm, input logic [31:0] exp);
    expQ.push_back('{nm, exp});
    bus(1'b0, a, 32'h0);
  endtask
  // Pin edges are four cycles apart so any input sampling keeps up
  task automatic edges(input int k);
    repeat (k) begin
      @(posedge clock);
      cpin <= 1'b1;
      repeat (2) @(posedge clock);
      cpin <= 1'b0;
      @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask
  // Tick count and read results are judged where they appear
  always @(posedge clock) ticks <= rst_n ? ticks + {31'h0, instTick} : 32'h0;
  // Read data are taken at the rising edge where waitrequest is low
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0 && expQ.size() > 0) begin
      cur = expQ.pop_front();
      chk(cur.nm, cur.v, readdata);
    end
  end
  always @(negedge clock) begin
    if (wdFlag === 1'b1 && !wdSeen) begin
      wdSeen = 1'b1;
      chk("watchdog ticks", {16'h0, mts_pkg::WDOG_RATIO}, ticks);
    end
  end
  initial begin
    logic [5:0] ofs [5];
    logic       lv;
    int k, n, p, sel, cnt;
    ofs = '{mts_pkg::PRESC_CTRL_OFS, mts_pkg::FIRST_CTRL_OFS, mts_pkg::SECOND_CTRL_OFS,
            mts_pkg::LONG_CTRL_OFS, mts_pkg::DISP_CTRL_OFS};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (k = 0; k < 5; k++) rd(ofs[k], "ctrl reset", 32'h0);
    bus(1'b1, 6'h3c, 32'hff);
    rd(6'h3c, "unmapped", 32'h0);
    for (k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      n = (k == 0) ? 0 : int'(seed[3:0]);
      bus(1'b1, mts_pkg::FIRST_CTRL_OFS, 32'h0);
      bus(1'b1, mts_pkg::FIRST_RELD_OFS, 32'(n));
      rd(mts_pkg::FIRST_CNT_OFS, "first load", 32'(n));
      bus(1'b1, mts_pkg::FLAGS_OFS, 32'h7);
      bus(1'b1, mts_pkg::FIRST_CTRL_OFS, 32'h7);
      for (p = 0; p < 2; p++) begin
        edges(n);
        rd(mts_pkg::FIRST_CNT_OFS, "first count", 32'h0);
        rd(mts_pkg::FLAGS_OFS, "flag early", 32'h0);
        edges(1);
        rd(mts_pkg::FLAGS_OFS, "flag at underflow", 32'h1);
        if (p == 0) begin
          @(posedge clock);
          intAccept <= 3'h1;
          @(posedge clock);
          intAccept <= 3'h0;
        end else begin
          bus(1'b1, mts_pkg::FLAGS_OFS, 32'h1);
        end
        rd(mts_pkg::FLAGS_OFS, "flag consumed", 32'h0);
      end
    end
    // start held until the interrupt edge
    bus(1'b1, mts_pkg::FIRST_CTRL_OFS, 32'h0);
    bus(1'b1, mts_pkg::FIRST_RELD_OFS, 32'h2);
    bus(1'b1, mts_pkg::FIRST_CTRL_OFS, 32'hf);
    edges(3);
    rd(mts_pkg::FLAGS_OFS, "sync held", 32'h0);
    @(posedge clock);
    extEdge <= 1'b1;
    @(posedge clock);
    extEdge <= 1'b0;
    edges(3);
    rd(mts_pkg::FLAGS_OFS, "sync started", 32'h1);
    // second timer on main osc edges; first timer counts the wave's rise
    bus(1'b1, mts_pkg::FIRST_CTRL_OFS, 32'h0);
    bus(1'b1, mts_pkg::FIRST_RELD_OFS, 32'h0);
    bus(1'b1, mts_pkg::SECOND_RELD_OFS, 32'h1);
    bus(1'b1, mts_pkg::FLAGS_OFS, 32'h7);
    bus(1'b1, mts_pkg::FIRST_CTRL_OFS, 32'h4);
    bus(1'b1, mts_pkg::SECOND_CTRL_OFS, 32'ha);
    for (k = 0; k < 4; k++) begin
      edges(1);
      // Reload 1 toggles the wave every second edge; eighth first underflow opens the pin
      lv = (k == 1 || k == 2);
      chk("pwm wave", {31'h0, lv}, {31'h0, pwmWave});
      chk("counter pin out", {31'h0, lv}, {31'h0, cpOut});
    end
    rd(mts_pkg::FLAGS_OFS, "wave flags", 32'h3);
    // long period measured between two underflows
    bus(1'b1, mts_pkg::PRESC_RELD_OFS, 32'h0);
    bus(1'b1, mts_pkg::PRESC_CTRL_OFS, 32'h1);
    for (sel = 0; sel < 2; sel++) begin
      bus(1'b1, mts_pkg::LONG_CTRL_OFS, 32'hc | 32'(sel));
      rd(mts_pkg::LONG_CTRL_OFS, "long ctrl", 32'hc | 32'(sel));
      bus(1'b1, mts_pkg::FLAGS_OFS, 32'h4);
      // Step off the write edge, where the flag still shows its old value
      @(negedge clock);
      for (cnt = 0; cnt < 70000 && timerIrq[2] !== 1'b1; cnt++) @(negedge clock);
      tmo(timerIrq[2] !== 1'b1);
      cnt = 0;
      do begin
        @(posedge clock);
        intAccept <= (cnt == 0) ? 3'h4 : 3'h0;
        @(negedge clock);
        cnt++;
      end while (cnt < 70000 && !(cnt > 2 && timerIrq[2] === 1'b1));
      chk("long period", 32'h1 << (mts_pkg::LONG_BASE_LOG2 + sel), 32'(cnt));
      tmo(cnt >= 70000);
    end
    // display clock from long bit 4, then from the system tick
    for (sel = 0; sel < 2; sel++) begin
      bus(1'b1, mts_pkg::DISP_CTRL_OFS, 32'h21 | 32'(sel << 4));
      @(negedge clock);
      lv = lcdClock;
      for (cnt = 0; cnt < 300 && lcdClock === lv; cnt++) @(negedge clock);
      tmo(lcdClock === lv);
      for (cnt = 0; cnt < 300 && lcdClock !== lv; cnt++) @(negedge clock);
      // Reload 1 divides by 2; the tap falls once per 32 long ticks
      p = (sel == 1) ? 2 : 2 << (mts_pkg::LONG_TAP_BIT + 1);
      chk("lcd half period", 32'(p), 32'(cnt));
      tmo(cnt >= 300);
    end
    // free-running watchdog raises its flag, no reset yet
    for (cnt = 0; cnt < 30000 && wdFlag !== 1'b1; cnt++) @(negedge clock);
    chk("watchdog flag", 32'h1, {31'h0, wdFlag});
    chk("reset request", 32'h0, {31'h0, sysRst});
    end_sim();
  end
endmodule
bind mts_timer_top mts_timer_sva chk (.clock(clock), .rst_n(rst_n), .ce(ce),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .instruction_clock_tick(instruction_clock_tick), .intAccept(intAccept),
  .timerIrq(timerIrq), .pwm_wave(pwm_wave), .counterPinOut(counterPinOut),
  .watchdog_flag(watchdog_flag), .sysResetReq(sysResetReq));
`default_nettype wire
